// ===== verilog/lhp_device.sv
// LCD device end: host port decode, control registers, driver mapping
`timescale 1ns/1ps
`include "lhp_defines.svh"
`default_nettype none
module lhp_device
  import lhp_pkg::*;
#(
  parameter int RAM_WORDS = 1024,
  parameter logic [2:0] CODE_68_16 = `LHP_MODE_68_16,
  parameter logic [2:0] CODE_68_8 = `LHP_MODE_68_8,
  parameter logic [2:0] CODE_80_16 = `LHP_MODE_80_16,
  parameter logic [2:0] CODE_80_8 = `LHP_MODE_80_8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Host pins
  lhp_if.device bus,
  // Straps
  input wire logic mode_strap_2,
  input wire logic mode_strap_1,
  input wire logic mode_strap_0,
  input wire logic amplifier_disable_strap,
  // Display scan from timing generator
  input wire logic [6:0] scan_line,
  input wire logic [127:0] scan_pixels,
  // Drive outputs
  output var lhp_level_e common_output [128],
  output logic [127:0] segment_output,
  output logic segment_enable,
  output logic amplifier_enable,
  output logic [2:0] boost_output
);
  logic [7:0] index_holding;
  logic [15:0] write_buffer;
  logic [15:0] read_buffer;
  logic [15:0] ctrl_reg, drv_reg, pwr_reg;
  logic [9:0] ram_addr;
  logic [15:0] ram [RAM_WORDS];
  logic rd_primed;
  lhp_mode_e mode;
  logic strobe_d, dir_d, rst_all;
  logic wr_ev, rd_ev, rd_act;
  logic [15:0] wdata;
  logic [4:0] ser_cnt;
  logic [23:0] ser_sh;
  logic ser_rd;
  logic [15:0] ser_out;

  assign rst_all = sys_rst || !bus.reset_n;

  // Strap decode
  always_ff @(posedge mclk) begin
    case ({mode_strap_2, mode_strap_1, mode_strap_0})
      CODE_68_16: mode <= lhp_m68_16;
      CODE_68_8: mode <= lhp_m68_8;
      CODE_80_16: mode <= lhp_m80_16;
      CODE_80_8: mode <= lhp_m80_8;
      default: mode <= lhp_mser;
    endcase
    amplifier_enable <= !amplifier_disable_strap;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      strobe_d <= 1'b0;
      dir_d <= 1'b1;
    end else begin
      strobe_d <= bus.strobe;
      dir_d <= bus.dir_in;
    end
  end

  // Parallel transfer events
  always_comb begin
    wr_ev = 1'b0;
    rd_ev = 1'b0;
    rd_act = 1'b0;
    wdata = bus.host_data_bus_in;
    if (mode == lhp_m68_8 || mode == lhp_m80_8) begin
      wdata = {bus.host_data_bus_in[15:8], 8'h00};
    end
    if (!bus.chip_select_n) begin
      case (mode)
        lhp_m68_16, lhp_m68_8: begin
          wr_ev = strobe_d && !bus.strobe && !bus.dir_in;
          rd_act = bus.strobe && bus.dir_in;
          rd_ev = strobe_d && !bus.strobe && dir_d;
        end
        lhp_m80_16, lhp_m80_8: begin
          wr_ev = !strobe_d && bus.strobe;
          rd_act = !bus.dir_in;
          rd_ev = !dir_d && bus.dir_in;
        end
        default: begin
          wr_ev = 1'b0;
        end
      endcase
    end
  end

  // Serial: 8-bit header {rs,rw,...}, then 16 data bits, msb first
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ser_cnt <= 5'h00;
      ser_sh <= 24'h000000;
    end else if (bus.chip_select_n || mode != lhp_mser) begin
      ser_cnt <= 5'h00;
    end else if (!strobe_d && bus.strobe) begin
      ser_sh <= {ser_sh[22:0], bus.dir_in};
      ser_cnt <= (ser_cnt == 5'd23) ? 5'h00 : ser_cnt + 5'h01;
    end
  end
  // Direction header bit moves up one place per shifted bit
  assign ser_rd = (mode == lhp_mser) && !bus.chip_select_n && ser_cnt >= 5'd8 && ser_sh[ser_cnt - 5'd2];

  // Register load and access decode
  always_ff @(posedge mclk or posedge rst_all) begin
    if (rst_all) begin
      index_holding <= 8'h00;
      write_buffer <= 16'h0000;
      ctrl_reg <= `LHP_RST_CTRL;
      drv_reg <= `LHP_RST_DRV;
      pwr_reg <= `LHP_RST_PWR;
      ram_addr <= 10'h000;
      read_buffer <= 16'h0000;
      rd_primed <= 1'b0;
    end else begin
      logic rs;
      logic [15:0] d;
      logic w;
      logic r;
      rs = bus.register_select;
      d = wdata;
      w = wr_ev;
      r = rd_ev && rs;
      if (mode == lhp_mser && !bus.chip_select_n && !strobe_d && bus.strobe && ser_cnt == 5'd23) begin
        rs = ser_sh[22];
        d = {ser_sh[14:0], bus.dir_in};
        w = !ser_sh[21];
      end
      if (w && !rs) begin
        index_holding <= d[7:0];
      end else if (w && rs) begin
        write_buffer <= d;
        case (index_holding)
          `LHP_IDX_CTRL: ctrl_reg <= d;
          `LHP_IDX_DRV: drv_reg <= d;
          `LHP_IDX_PWR: pwr_reg <= d;
          `LHP_IDX_ADDR: ram_addr <= d[9:0];
          `LHP_IDX_RAM: begin
            ram[ram_addr] <= d;
            ram_addr <= ram_addr + 10'h001;
          end
          default: ;
        endcase
      end
      if (r && index_holding == `LHP_IDX_RAM) begin
        read_buffer <= ram[ram_addr];
        if (rd_primed) begin
          ram_addr <= ram_addr + 10'h001;
        end
        rd_primed <= 1'b1;
      end else if (w) begin
        rd_primed <= 1'b0;
      end
    end
  end

  // Bus drive only during reads with select high
  always_comb begin
    bus.dev_data_oe = !bus.chip_select_n && rd_act && bus.register_select;
    bus.host_data_bus_dev = read_buffer;
    ser_out = read_buffer << (ser_cnt - 5'd8);
    bus.dev_sda_out = ser_out[15];
    bus.dev_sda_oe = ser_rd;
  end

  // Driver mapping
  logic blank;
  assign blank = !ctrl_reg[`LHP_BIT_DISP] || ctrl_reg[`LHP_BIT_SLEEP] || pwr_reg[`LHP_BIT_STBY];
  always_ff @(posedge mclk or posedge rst_all) begin
    if (rst_all) begin
      for (int i = 0; i < 128; i++) begin
        common_output[i] <= lhp_drv_ground;
      end
      segment_output <= 128'h0;
      segment_enable <= 1'b0;
      boost_output <= 3'h0;
    end else begin
      boost_output <= pwr_reg[`LHP_BOOST_LSB +: 3];
      segment_enable <= !blank;
      for (int i = 0; i < 128; i++) begin
        logic [6:0] pos;
        logic [6:0] line;
        pos = ctrl_reg[`LHP_BIT_CMS] ? 7'(127 - i) : 7'(i);
        line = pos - {ctrl_reg[`LHP_CN_LSB +: 2], 3'b000};
        if (blank) begin
          common_output[i] <= lhp_drv_ground;
        end else if (line > {drv_reg[`LHP_LINES_LSB +: 4], 3'b111}) begin
          common_output[i] <= lhp_drv_unsel;
        end else begin
          common_output[i] <= (line == scan_line) ? lhp_drv_sel : lhp_drv_unsel;
        end
        segment_output[i] <= blank ? 1'b0 :
          (ctrl_reg[`LHP_BIT_SGS] ? scan_pixels[127 - i] : scan_pixels[i]);
      end
    end
  end
endmodule
`default_nettype wire

// ===== verilog/lhp_defines.svh
// Timing counts, field positions and reset values of the LCD host port
`ifndef LHP_DEFINES_SVH
`define LHP_DEFINES_SVH
`define LHP_CLK_MHZ 100
`define LHP_STROBE_NS 40
`define LHP_STROBE_CYC ((`LHP_STROBE_NS * `LHP_CLK_MHZ + 999) / 1000)
`define LHP_SER_HALF_NS 50
`define LHP_SER_HALF_CYC ((`LHP_SER_HALF_NS * `LHP_CLK_MHZ + 999) / 1000)
`define LHP_IDX_CTRL 8'h07
`define LHP_IDX_DRV 8'h01
`define LHP_IDX_PWR 8'h03
`define LHP_IDX_RAM 8'h22
`define LHP_IDX_ADDR 8'h21
`define LHP_BIT_DISP 0
`define LHP_BIT_SLEEP 1
`define LHP_BIT_STBY 0
`define LHP_BIT_CMS 8
`define LHP_BIT_SGS 9
`define LHP_CN_LSB 4
`define LHP_BOOST_LSB 8
`define LHP_LINES_LSB 0
`define LHP_RST_CTRL 16'h0000
`define LHP_RST_DRV 16'h000F
`define LHP_RST_PWR 16'h0000
`define LHP_MODE_68_16 3'h0
`define LHP_MODE_68_8 3'h1
`define LHP_MODE_80_16 3'h2
`define LHP_MODE_80_8 3'h3
`define LHP_MODE_SER 3'h4
`define LHP_HOST_WR 2'h1
`define LHP_HOST_RD 2'h2
`endif

// ===== verilog/lhp_pkg.sv
// Types shared by both ends of the LCD host port
`default_nettype none
package lhp_pkg;
  typedef enum logic [2:0] {lhp_m68_16, lhp_m68_8, lhp_m80_16, lhp_m80_8, lhp_mser} lhp_mode_e;
  typedef enum logic [1:0] {lhp_drv_ground, lhp_drv_unsel, lhp_drv_sel} lhp_level_e;
endpackage
`default_nettype wire

// ===== verilog/lhp_if.sv
// Pin bundle between host processor and LCD device
`timescale 1ns/1ps
`default_nettype none
interface lhp_if;
  logic chip_select_n;
  logic register_select;
  logic strobe;
  logic dir_out;
  logic dir_oe;
  logic dir_in;
  logic [15:0] host_data_bus_out;
  logic host_data_bus_oe;
  logic [15:0] host_data_bus_dev;
  logic dev_data_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic [15:0] host_data_bus_in;
  logic reset_n;
  // Resolved wire levels
  assign host_data_bus_in = dev_data_oe ? host_data_bus_dev : host_data_bus_out;
  assign dir_in = dev_sda_oe ? dev_sda_out : (dir_oe ? dir_out : 1'b1);
  modport host (output chip_select_n, register_select, strobe, dir_out, dir_oe, host_data_bus_out,
    host_data_bus_oe, reset_n, input dir_in, host_data_bus_in);
  modport device (input chip_select_n, register_select, strobe, dir_in, host_data_bus_in, reset_n,
    output host_data_bus_dev, dev_data_oe, dev_sda_out, dev_sda_oe);
endinterface
`default_nettype wire

// ===== verilog/lhp_host.sv
// Host processor end: drives 68 or 80 style strobes from a simple command port
`timescale 1ns/1ps
`include "lhp_defines.svh"
`default_nettype none
module lhp_host
  import lhp_pkg::*;
#(
  parameter bit STYLE_80 = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Command port
  input wire logic [1:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  output logic [15:0] cmd_rdata,
  output logic busy,
  // Pins
  lhp_if.host bus
);
  typedef enum logic [1:0] {lhp_idle, lhp_assert, lhp_release} lhp_hstate_e;
  lhp_hstate_e state;
  logic [7:0] cnt;
  logic is_rd;
  logic [15:0] rd_data;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= lhp_idle;
      cnt <= 8'h00;
      is_rd <= 1'b0;
      busy <= 1'b0;
      cmd_rdata <= 16'h0000;
      rd_data <= 16'h0000;
      bus.chip_select_n <= 1'b1;
      bus.register_select <= 1'b0;
      bus.strobe <= STYLE_80;
      bus.dir_out <= STYLE_80;
      bus.dir_oe <= 1'b1;
      bus.host_data_bus_out <= 16'h0000;
      bus.host_data_bus_oe <= 1'b1;
      bus.reset_n <= 1'b0;
    end else begin
      bus.reset_n <= 1'b1;
      if (cmd_rd && cmd_addr == 2'h3) begin
        cmd_rdata <= rd_data;
      end else if (cmd_rd) begin
        cmd_rdata <= {15'h0000, busy};
      end
      case (state)
        lhp_idle: begin
          if (!busy && (cmd_wr || cmd_rd) && cmd_addr[1] == 1'b0) begin
            is_rd <= cmd_rd;
            busy <= 1'b1;
            bus.chip_select_n <= 1'b0;
            bus.register_select <= cmd_addr[0];
            bus.host_data_bus_out <= cmd_wdata;
            bus.host_data_bus_oe <= !cmd_rd;
            bus.dir_out <= STYLE_80 ? 1'b1 : cmd_rd;
            cnt <= 8'(`LHP_STROBE_CYC);
            state <= lhp_assert;
          end
        end
        lhp_assert: begin
          if (STYLE_80) begin
            if (is_rd) bus.dir_out <= 1'b0;
            else bus.strobe <= 1'b0;
          end else begin
            bus.strobe <= 1'b1;
          end
          if (cnt == 8'h00) begin
            rd_data <= bus.host_data_bus_in;
            cnt <= 8'(`LHP_STROBE_CYC);
            state <= lhp_release;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        lhp_release: begin
          bus.strobe <= STYLE_80;
          // 68 style holds direction past the enable fall
          if (STYLE_80) begin
            bus.dir_out <= 1'b1;
          end
          bus.host_data_bus_oe <= 1'b1;
          if (cnt == 8'h00) begin
            bus.chip_select_n <= 1'b1;
            bus.dir_out <= 1'b1;
            busy <= 1'b0;
            state <= lhp_idle;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        default: state <= lhp_idle;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== bench/lhp_link_props.sv
// Link checks between host and device ends
`timescale 1ns/1ps
`default_nettype none
module lhp_link_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Link pins
  input wire logic chip_select_n,
  input wire logic register_select,
  input wire logic strobe,
  input wire logic dir_out,
  input wire logic [15:0] host_data_bus_out,
  input wire logic host_data_bus_oe,
  input wire logic dev_data_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence wr_start;
    $fell(strobe) && !chip_select_n;
  endsequence
  sequence wr_hold;
    (!strobe && $stable(host_data_bus_out))[*3];
  endsequence
  sequence rd_start;
    $fell(dir_out) && !chip_select_n && register_select;
  endsequence
  a_rd_needs_cs: assert property (dev_data_oe |-> !chip_select_n)
    else $error("bus driven while unselected");
  a_rd_needs_rs: assert property (dev_data_oe |-> register_select)
    else $error("bus driven on index side");
  a_no_bus_fight: assert property (!(dev_data_oe && host_data_bus_oe))
    else $error("both ends drive the bus");
  a_strobes_apart: assert property (!(!strobe && !dir_out))
    else $error("write and read strobes together");
  a_wr_needs_cs: assert property (!strobe |-> !chip_select_n)
    else $error("write strobe while unselected");
  a_wr_data_hold: assert property (wr_start |-> host_data_bus_oe ##1 wr_hold)
    else $error("write data moved under strobe");
  a_rd_drives_bus: assert property (rd_start |-> ##[0:2] dev_data_oe)
    else $error("read data not driven");
  a_rd_releases: assert property ($rose(dir_out) |-> ##[0:2] !dev_data_oe)
    else $error("bus held after read");
endmodule
`default_nettype wire

// ===== bench/test_lcd_host_port_and_driver_mapping.sv
// Bench joining host and device ends of the LCD port
`timescale 1ns/1ps
`include "lhp_defines.svh"
`default_nettype none
module test_lcd_host_port_and_driver_mapping;
  import lhp_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] cmd_addr = 2'h0;
  logic [15:0] cmd_wdata = 16'h0000;
  logic cmd_wr = 1'b0;
  logic cmd_rd = 1'b0;
  logic [15:0] cmd_rdata;
  logic busy;
  logic amp_strap = 1'b0;
  logic [6:0] scan_line = 7'h05;
  logic [127:0] scan_pixels = 128'h0123456789ABCDEFFEDCBA9876543211;
  lhp_level_e common_output [128];
  logic [127:0] segment_output;
  logic segment_enable;
  logic amplifier_enable;
  logic [2:0] boost_output;
  logic [2:0] m68_strap = 3'h0;
  logic [15:0] cmd_rdata_68;
  logic busy_68;
  lhp_level_e common_output_68 [128];
  logic [127:0] segment_output_68;
  logic segment_enable_68;
  logic amplifier_enable_68;
  logic [2:0] boost_output_68;
  int n_fail = 0;
  int compares = 0;
  lhp_if bus ();
  lhp_if bus_68 ();
  // Second pair in 68 style, fed the same commands
  lhp_host #(.STYLE_80(1'b0)) lhp_host_68_inst (.mclk(mclk), .sys_rst(sys_rst), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata_68), .busy(busy_68),
    .bus(bus_68));
  lhp_device lhp_device_68_inst (.mclk(mclk), .sys_rst(sys_rst), .bus(bus_68), .mode_strap_2(m68_strap[2]),
    .mode_strap_1(m68_strap[1]), .mode_strap_0(m68_strap[0]), .amplifier_disable_strap(amp_strap),
    .scan_line(scan_line), .scan_pixels(scan_pixels), .common_output(common_output_68),
    .segment_output(segment_output_68), .segment_enable(segment_enable_68),
    .amplifier_enable(amplifier_enable_68), .boost_output(boost_output_68));
  lhp_host lhp_host_inst (.mclk(mclk), .sys_rst(sys_rst), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata), .busy(busy), .bus(bus));
  lhp_device lhp_device_inst (.mclk(mclk), .sys_rst(sys_rst), .bus(bus), .mode_strap_2(1'b0),
    .mode_strap_1(1'b1), .mode_strap_0(1'b0), .amplifier_disable_strap(amp_strap), .scan_line(scan_line),
    .scan_pixels(scan_pixels), .common_output(common_output), .segment_output(segment_output),
    .segment_enable(segment_enable), .amplifier_enable(amplifier_enable), .boost_output(boost_output));
  lhp_link_props lhp_link_props_inst (.mclk(mclk), .sys_rst(sys_rst), .chip_select_n(bus.chip_select_n),
    .register_select(bus.register_select), .strobe(bus.strobe), .dir_out(bus.dir_out),
    .host_data_bus_out(bus.host_data_bus_out), .host_data_bus_oe(bus.host_data_bus_oe),
    .dev_data_oe(bus.dev_data_oe));
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("Compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // One command, then wait for the port to go idle
  task automatic host_op(input logic [1:0] a, input logic [15:0] d, input logic rd);
    @(posedge mclk);
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_wr <= !rd;
    cmd_rd <= rd;
    @(posedge mclk);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(negedge mclk);
      if (busy === 1'b0 && busy_68 === 1'b0) break;
    end
    check(128'(busy), 128'h0);
    check(128'(busy_68), 128'h0);
    @(posedge mclk);
  endtask
  task automatic reg_wr(input logic [7:0] idx, input logic [15:0] d);
    host_op(2'h0, {8'h00, idx}, 1'b0);
    host_op(2'h1, d, 1'b0);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic ram_read(output logic [15:0] v, output logic [15:0] v68);
    host_op(2'h1, 16'h0000, 1'b1);
    cmd_addr <= 2'h3;
    cmd_rd <= 1'b1;
    @(posedge mclk);
    cmd_rd <= 1'b0;
    @(negedge mclk);
    v = cmd_rdata;
    v68 = cmd_rdata_68;
  endtask
  task automatic t_reset;
    check(128'(segment_enable), 128'h0);
    check(segment_output, 128'h0);
    check(128'(common_output[5]), 128'(lhp_drv_ground));
    check(128'(amplifier_enable), 128'h1);
    check(128'(boost_output), 128'h0);
    check(128'(segment_enable_68), 128'h0);
    check(128'(common_output_68[5]), 128'(lhp_drv_ground));
    check(128'(amplifier_enable_68), 128'h1);
  endtask
  task automatic t_map;
    logic [127:0] rev;
    rev = {<<{scan_pixels}};
    reg_wr(`LHP_IDX_CTRL, 16'h0001);
    check(128'(segment_enable), 128'h1);
    check(128'(segment_enable_68), 128'h1);
    check(segment_output_68, scan_pixels);
    check(segment_output, scan_pixels);
    check(128'(common_output[5]), 128'(lhp_drv_sel));
    check(128'(common_output[6]), 128'(lhp_drv_unsel));
    reg_wr(`LHP_IDX_CTRL, 16'h0301);
    check(segment_output, rev);
    check(128'(common_output[122]), 128'(lhp_drv_sel));
    reg_wr(`LHP_IDX_CTRL, 16'h0011);
    check(128'(common_output[13]), 128'(lhp_drv_sel));
    @(posedge mclk);
    scan_line <= 7'h14;
    reg_wr(`LHP_IDX_DRV, 16'h0000);
    check(128'(common_output[28]), 128'(lhp_drv_unsel));
  endtask
  // Display off, sleep, then standby with a boost factor
  task automatic t_blank;
    logic [15:0] ctl [3] = '{16'h0000, 16'h0003, 16'h0001};
    logic [15:0] pwr [3] = '{16'h0000, 16'h0000, 16'h0501};
    for (int k = 0; k < 3; k++) begin
      reg_wr(`LHP_IDX_CTRL, ctl[k]);
      reg_wr(`LHP_IDX_PWR, pwr[k]);
      check(128'(segment_enable), 128'h0);
      check(segment_output, 128'h0);
      check(128'(common_output[5]), 128'(lhp_drv_ground));
    end
    check(128'(boost_output), 128'h5);
    check(128'(boost_output_68), 128'h5);
    reg_wr(`LHP_IDX_PWR, 16'h0000);
    check(128'(segment_enable), 128'h1);
  endtask
  task automatic t_ram;
    logic [15:0] v;
    logic [15:0] v68;
    host_op(2'h0, 16'h0000, 1'b1);
    reg_wr(`LHP_IDX_ADDR, 16'h0000);
    reg_wr(`LHP_IDX_RAM, 16'hA5C3);
    reg_wr(`LHP_IDX_ADDR, 16'h0000);
    host_op(2'h0, {8'h00, `LHP_IDX_RAM}, 1'b0);
    ram_read(v, v68);
    ram_read(v, v68);
    check(128'(v), 128'hA5C3);
    check(128'(v68), 128'hA5C3);
    @(posedge mclk);
    amp_strap <= 1'b1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    check(128'(amplifier_enable), 128'h0);
  endtask
  // Narrow bus: only the upper byte lands, low byte is zero
  task automatic t_narrow;
    host_op(2'h0, {8'h00, `LHP_IDX_CTRL}, 1'b0);
    m68_strap <= `LHP_MODE_68_8;
    host_op(2'h1, 16'h0101, 1'b0);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    check(128'(segment_enable_68), 128'h0);
    check(128'(segment_enable), 128'h1);
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    @(negedge mclk);
    t_reset();
    t_map();
    t_blank();
    t_ram();
    t_narrow();
    summarize();
  end
  initial begin
    #200000;
    n_fail++;
    summarize();
  end
endmodule
`default_nettype wire
